// File: bench/mac_adc_model.sv
`timescale 1ns/1ps
`default_nettype none
// converter front end and the pulled-up alert wire that the block drives
module mac_adc_model (
  input  wire logic signed [15:0] shunt_lvl_i,
  input  wire logic [15:0]        bus_lvl_i,
  input  wire logic               alert_i,
  input  wire logic               alert_oe_i,
  output logic signed [15:0]      shunt_o,
  output logic [15:0]             bus_o,
  output logic                    pin_o
);
  // levels are held steady, so whichever cycle a conversion ends sees them
  assign shunt_o = shunt_lvl_i;
  assign bus_o   = bus_lvl_i;
  // released open drain reads the pull-up, never the last driven value
  assign pin_o   = alert_oe_i ? alert_i : 1'b1;
endmodule : mac_adc_model
`default_nettype wire

// File: bench/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "mac_map.svh"
module tb;
  logic               clk = 1'b0;
  logic               rst_b = 1'b0;
  logic [7:0]         awaddr = 8'h00;
  logic [7:0]         araddr = 8'h00;
  logic [31:0]        wdata = 32'h0;
  logic [3:0]         wstrb = 4'h0;
  logic               awvalid = 1'b0;
  logic               wvalid = 1'b0;
  logic               bready = 1'b0;
  logic               arvalid = 1'b0;
  logic               rready = 1'b0;
  logic signed [15:0] shunt_lvl = 16'sh0000;
  logic [15:0]        bus_lvl = 16'h0000;
  logic [31:0]        rd;
  logic [1:0]         rsp;
  wire logic          awready, wready, bvalid, arready, rvalid, alert, alert_oe, pin;
  wire logic [1:0]    bresp, rresp;
  wire logic [31:0]   rdata;
  wire logic signed [15:0] shunt_s;
  wire logic [15:0]   bus_s;
  int                 mismatches = 0;
  int                 checks = 0;

  // 40 MHz system clock
  always #12.5 clk = ~clk;

  mac_top #(.CYC_PER_US(1)) i_mac_top (
    .CLK_SYS_I(clk), .RST_B_I(rst_b),
    .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awvalid), .S_AXI_AWREADY_O(awready),
    .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(wstrb), .S_AXI_WVALID_I(wvalid),
    .S_AXI_WREADY_O(wready), .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid),
    .S_AXI_BREADY_I(bready), .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid),
    .S_AXI_ARREADY_O(arready), .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp),
    .S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(rready),
    .SHUNT_SAMPLE_I(shunt_s), .BUS_SAMPLE_I(bus_s),
    .ALERT_O(alert), .ALERT_OE_O(alert_oe)
  );

  mac_adc_model i_mac_adc_model (
    .shunt_lvl_i(shunt_lvl), .bus_lvl_i(bus_lvl), .alert_i(alert),
    .alert_oe_i(alert_oe), .shunt_o(shunt_s), .bus_o(bus_s), .pin_o(pin)
  );

  task automatic results;
    $display("mismatches=%0d checks=%0d", mismatches, checks);
    if (mismatches == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : results

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // one edge of a bounded wait; running out counts as a mismatch
  task automatic step(inout int n);
    @(posedge clk);
    n++;
    if (n > 60) begin
      mismatches++;
      results();
    end
  endtask : step

  task automatic wr(input logic [7:0] idx, input logic [15:0] d);
    int   n;
    logic aw_ok;
    logic w_ok;
    n = 0;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    awaddr  <= idx << 2;
    wdata   <= {16'h0000, d};
    wstrb   <= 4'h3;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      step(n);
      if (awready && !aw_ok) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (wready && !w_ok) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    bready <= 1'b1;
    do step(n); while (!bvalid);
    rsp = bresp;
    bready <= 1'b0;
  endtask : wr

  task automatic rdr(input logic [7:0] idx);
    int n;
    n = 0;
    araddr  <= idx << 2;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do step(n); while (!arready);
    arvalid <= 1'b0;
    do step(n); while (!rvalid);
    rd = rdata;
    rsp = rresp;
    rready <= 1'b0;
    // let an edge pass so a following read never re-raises rready in this step
    @(posedge clk);
  endtask : rdr

  task automatic t_reset;
    rdr(`MAC_IDX_CONFIG);
    chk(rd, 32'h0127);
    rdr(`MAC_IDX_MASK);
    chk(rd, 32'h0000);
    wr(`MAC_IDX_SHUNT, 16'h1234);
    chk({30'h0, rsp}, 32'h2);
  endtask : t_reset

  // both shunt limits enabled: only the over-limit one may act
  task automatic t_sol;
    shunt_lvl <= 16'sh0200;
    bus_lvl   <= 16'h0050;
    wr(`MAC_IDX_LIMIT, 16'h0100);
    wr(`MAC_IDX_MASK, 16'hc000);
    wr(`MAC_IDX_CONFIG, 16'h0009);
    repeat (180) @(posedge clk);
    // shunt conversion still running: no compare may have happened yet
    chk({31'h0, pin}, 32'h1);
    rdr(`MAC_IDX_MASK);
    chk(rd, 32'hc000);
    repeat (220) @(posedge clk);
    chk({31'h0, pin}, 32'h0);
    rdr(`MAC_IDX_MASK);
    chk(rd, 32'hc018);
    rdr(`MAC_IDX_MASK);
    chk(rd, 32'hc010);
    repeat (400) @(posedge clk);
    rdr(`MAC_IDX_MASK);
    chk(rd, 32'hc010);
    rdr(`MAC_IDX_SHUNT);
    chk(rd, 32'h0200);
    rdr(`MAC_IDX_POWER);
    chk(rd, 32'h000a);
  endtask : t_sol

  // ready signalling with active-high polarity; bus stays in range
  task automatic t_pol;
    wr(`MAC_IDX_MASK, 16'h2403);
    wr(`MAC_IDX_CONFIG, 16'h0001);
    repeat (400) @(posedge clk);
    chk({31'h0, pin}, 32'h1);
    rdr(`MAC_IDX_MASK);
    chk(rd, 32'h240b);
    repeat (3) @(posedge clk);
    chk({31'h0, pin}, 32'h0);
  endtask : t_pol

  // latched bus over-limit in continuous mode, then power-down
  task automatic t_latch;
    bus_lvl <= 16'h0200;
    wr(`MAC_IDX_MASK, 16'h2001);
    wr(`MAC_IDX_CONFIG, 16'h0007);
    repeat (300) @(posedge clk);
    bus_lvl <= 16'h0010;
    repeat (300) @(posedge clk);
    chk({31'h0, pin}, 32'h0);
    rdr(`MAC_IDX_MASK);
    chk(rd, 32'h2019);
    repeat (3) @(posedge clk);
    chk({31'h0, pin}, 32'h1);
    repeat (300) @(posedge clk);
    // ready is set again by now, but with its enable off it must not pull the pin
    chk({31'h0, pin}, 32'h1);
    wr(`MAC_IDX_CONFIG, 16'h0000);
    rdr(`MAC_IDX_MASK);
    chk(rd, 32'h2009);
    repeat (500) @(posedge clk);
    rdr(`MAC_IDX_MASK);
    chk(rd, 32'h2001);
    wr(`MAC_IDX_CONFIG, 16'h0001);
    repeat (300) @(posedge clk);
    rdr(`MAC_IDX_MASK);
    chk(rd, 32'h2001);
    repeat (150) @(posedge clk);
    rdr(`MAC_IDX_MASK);
    chk(rd, 32'h2009);
  endtask : t_latch

  // power limit over four averages: first raw sample over, the average in range
  task automatic t_avg;
    bus_lvl <= 16'h0050;
    wr(`MAC_IDX_LIMIT, 16'h0008);
    wr(`MAC_IDX_MASK, 16'h0800);
    wr(`MAC_IDX_CONFIG, 16'h0201);
    repeat (300) @(posedge clk);
    bus_lvl <= 16'h0010;
    chk({31'h0, pin}, 32'h0);
    rdr(`MAC_IDX_MASK);
    chk(rd, 32'h0810);
    repeat (900) @(posedge clk);
    chk({31'h0, pin}, 32'h1);
    rdr(`MAC_IDX_MASK);
    chk(rd, 32'h0808);
    rdr(`MAC_IDX_POWER);
    chk(rd, 32'h0004);
    rdr(`MAC_IDX_BUS);
    chk(rd, 32'h0020);
    rdr(`MAC_IDX_STATUS);
    chk(rd, 32'h0000);
  endtask : t_avg

  // reset, let recovery pass, then run the scenarios
  initial begin
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    repeat (120) @(posedge clk);
    t_reset();
    t_sol();
    t_pol();
    t_latch();
    t_avg();
    results();
  end
endmodule : tb
`default_nettype wire

// File: rtl/mac_map.svh
`ifndef MAC_MAP_SVH
`define MAC_MAP_SVH
// register indices; byte address is four times the index
`define MAC_IDX_CONFIG   8'h00
`define MAC_IDX_MASK     8'h06
`define MAC_IDX_LIMIT    8'h07
`define MAC_IDX_SHUNT    8'h08
`define MAC_IDX_BUS      8'h09
`define MAC_IDX_POWER    8'h0a
`define MAC_IDX_STATUS   8'h0b
// reset values
`define MAC_RST_CONFIG   16'h0127
`define MAC_RST_MASK     16'h0000
`define MAC_RST_LIMIT    16'h0000
// alert mask/enable layout
`define MAC_MSK_WMASK    16'hfc03
`define MAC_BIT_SOL      15
`define MAC_BIT_SUL      14
`define MAC_BIT_BOL      13
`define MAC_BIT_BUL      12
`define MAC_BIT_POL      11
`define MAC_BIT_READY_SIGNAL_ENABLE     10
`define MAC_BIT_AFF      4
`define MAC_BIT_CONVERSION_READY_FLAG     3
`define MAC_BIT_WARNING_POLARITY_SELECT     1
`define MAC_BIT_LEN      0
// status layout
`define MAC_BIT_BUSY     0
`define MAC_BIT_RECOV    1
// operating modes
`define MAC_MODE_DOWN    3'h0
`define MAC_MODE_SINGLE  3'h1
`define MAC_MODE_CONT    3'h7
// timing
`define MAC_CLK_MHZ      40
`define MAC_T_RECOVER_US 100
`define MAC_T_CONV0_US   140
`define MAC_T_CONV1_US   204
`define MAC_T_CONV2_US   332
`define MAC_T_CONV3_US   588
`define MAC_T_CONV4_US   1100
`define MAC_T_CONV5_US   2116
`define MAC_T_CONV6_US   4156
`define MAC_T_CONV7_US   8244
// power product scaling
`define MAC_PWR_SHIFT    12
// bus responses
`define MAC_RESP_OKAY    2'h0
`define MAC_RESP_SLVERR  2'h2
`endif

// File: rtl/mac_pkg.sv
`default_nettype none
package mac_pkg;
  // sequencer states
  typedef enum logic [2:0] {
    ST_DOWN,
    ST_RECOVER,
    ST_IDLE,
    ST_SHUNT,
    ST_BUS
  } mac_state_t;

  // selected limit function
  typedef enum logic [2:0] {
    FN_NONE,
    FN_SOL,
    FN_SUL,
    FN_BOL,
    FN_BUL,
    FN_POL
  } mac_func_t;

  // configuration register layout
  typedef struct packed {
    logic [3:0] rsv;
    logic [2:0] avg;
    logic [2:0] bus_ct;
    logic [2:0] shunt_ct;
    logic [2:0] mode;
  } mac_cfg_t;
endpackage : mac_pkg
`default_nettype wire

// File: rtl/mac_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "mac_map.svh"
module mac_top #(
  parameter int unsigned CYC_PER_US = `MAC_CLK_MHZ,
  parameter int unsigned CNT_W      = 20,
  parameter int unsigned AW         = 8
) (
  input  wire logic               CLK_SYS_I,
  input  wire logic               RST_B_I,
  input  wire logic [AW-1:0]      S_AXI_AWADDR_I,
  input  wire logic               S_AXI_AWVALID_I,
  output logic                    S_AXI_AWREADY_O,
  input  wire logic [31:0]        S_AXI_WDATA_I,
  input  wire logic [3:0]         S_AXI_WSTRB_I,
  input  wire logic               S_AXI_WVALID_I,
  output logic                    S_AXI_WREADY_O,
  output logic [1:0]              S_AXI_BRESP_O,
  output logic                    S_AXI_BVALID_O,
  input  wire logic               S_AXI_BREADY_I,
  input  wire logic [AW-1:0]      S_AXI_ARADDR_I,
  input  wire logic               S_AXI_ARVALID_I,
  output logic                    S_AXI_ARREADY_O,
  output logic [31:0]             S_AXI_RDATA_O,
  output logic [1:0]              S_AXI_RRESP_O,
  output logic                    S_AXI_RVALID_O,
  input  wire logic               S_AXI_RREADY_I,
  input  wire logic signed [15:0] SHUNT_SAMPLE_I,
  input  wire logic [15:0]        BUS_SAMPLE_I,
  output logic                    ALERT_O,
  output logic                    ALERT_OE_O
);
  localparam int unsigned REC_CYC = `MAC_T_RECOVER_US * CYC_PER_US;

  // ---- functions ----
  // conversion time select to cycle count minus one
  function automatic logic [CNT_W-1:0] conv_cyc(input logic [2:0] sel);
    int unsigned us;
    case (sel)
      3'h0: us = `MAC_T_CONV0_US;
      3'h1: us = `MAC_T_CONV1_US;
      3'h2: us = `MAC_T_CONV2_US;
      3'h3: us = `MAC_T_CONV3_US;
      3'h4: us = `MAC_T_CONV4_US;
      3'h5: us = `MAC_T_CONV5_US;
      3'h6: us = `MAC_T_CONV6_US;
      default: us = `MAC_T_CONV7_US;
    endcase
    return CNT_W'(us * CYC_PER_US - 1);
  endfunction : conv_cyc

  // averaging select to log2 of sample count
  function automatic logic [3:0] avg_shift(input logic [2:0] sel);
    case (sel)
      3'h0: avg_shift = 4'h0;
      3'h1: avg_shift = 4'h2;
      3'h2: avg_shift = 4'h4;
      3'h3: avg_shift = 4'h6;
      3'h4: avg_shift = 4'h7;
      3'h5: avg_shift = 4'h8;
      3'h6: avg_shift = 4'h9;
      default: avg_shift = 4'ha;
    endcase
  endfunction : avg_shift

  // byte address to register index
  function automatic logic [7:0] reg_idx(input logic [AW-1:0] a);
    return 8'(a >> 2);
  endfunction : reg_idx

  // highest enabled bit wins
  function automatic mac_pkg::mac_func_t sel_func(input logic [15:0] m);
    if (m[`MAC_BIT_SOL])      sel_func = mac_pkg::FN_SOL;
    else if (m[`MAC_BIT_SUL]) sel_func = mac_pkg::FN_SUL;
    else if (m[`MAC_BIT_BOL]) sel_func = mac_pkg::FN_BOL;
    else if (m[`MAC_BIT_BUL]) sel_func = mac_pkg::FN_BUL;
    else if (m[`MAC_BIT_POL]) sel_func = mac_pkg::FN_POL;
    else                      sel_func = mac_pkg::FN_NONE;
  endfunction : sel_func

  // ---- declarations ----
  logic                     aw_rdy_q, w_rdy_q, bvalid_q, ar_rdy_q, rvalid_q;
  logic [1:0]               bresp_q, rresp_q;
  logic [31:0]              rdata_q, wdata_q;
  logic [3:0]               wstrb_q;
  logic [AW-1:0]            awaddr_q;
  logic [15:0]              cfg_q, mask_q, lim_q, be16, cfg_new;
  mac_pkg::mac_cfg_t        cfg, cfg_nw;
  mac_pkg::mac_state_t      state_q;
  mac_pkg::mac_func_t       func;
  logic [CNT_W-1:0]         cnt_q;
  logic                     trig_q, aff_q, conversion_ready_flag_q, alert_oe_q;
  logic [10:0]              n_q;
  logic signed [15:0]       shunt_last_q, res_sh_q;
  logic [15:0]              res_bus_q, res_pw_q, pwr;
  logic signed [26:0]       acc_sh_q, sum_sh;
  logic [25:0]              acc_bus_q, acc_pw_q, sum_bus, sum_pw;
  logic [31:0]              pwr_full;
  logic [15:0]              shunt_mag;
  logic                     wr_go, rd_go, cfg_wr, cfg_pd, mask_wr, lim_wr, mask_rd;
  logic                     cnt_zero, shunt_end, bus_end, n_last, cyc_done;
  logic                     sh_viol, bus_viol, cmp_evt, cmp_viol, alert_act, new_active;
  logic [3:0]               shf;
  logic [31:0]              rd_mux;
  logic [1:0]               rd_resp;

  // ---- write channel decode ----
  assign wr_go      = !aw_rdy_q && !w_rdy_q && !bvalid_q;
  assign be16       = {{8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
  assign cfg_new    = (cfg_q & ~be16) | (wdata_q[15:0] & be16);
  assign cfg        = mac_pkg::mac_cfg_t'(cfg_q);
  assign cfg_nw     = mac_pkg::mac_cfg_t'(cfg_new);
  assign cfg_wr     = wr_go && reg_idx(awaddr_q) == `MAC_IDX_CONFIG && |wstrb_q[1:0];
  assign cfg_pd     = cfg_wr && !new_active;
  assign new_active = cfg_nw.mode == `MAC_MODE_SINGLE || cfg_nw.mode == `MAC_MODE_CONT;
  assign mask_wr    = wr_go && reg_idx(awaddr_q) == `MAC_IDX_MASK;
  assign lim_wr     = wr_go && reg_idx(awaddr_q) == `MAC_IDX_LIMIT;
  assign rd_go      = S_AXI_ARVALID_I && ar_rdy_q;
  assign mask_rd    = rd_go && reg_idx(S_AXI_ARADDR_I) == `MAC_IDX_MASK;

  // address and data are caught separately, in either order
  always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      aw_rdy_q <= 1'b1;
      w_rdy_q  <= 1'b1;
      bvalid_q <= 1'b0;
      bresp_q  <= `MAC_RESP_OKAY;
      awaddr_q <= '0;
      wdata_q  <= '0;
      wstrb_q  <= '0;
    end else begin
      if (S_AXI_AWVALID_I && aw_rdy_q) begin
        aw_rdy_q <= 1'b0;
        awaddr_q <= S_AXI_AWADDR_I;
      end
      if (S_AXI_WVALID_I && w_rdy_q) begin
        w_rdy_q <= 1'b0;
        wdata_q <= S_AXI_WDATA_I;
        wstrb_q <= S_AXI_WSTRB_I;
      end
      if (wr_go) begin
        bvalid_q <= 1'b1;
        bresp_q  <= (cfg_wr || mask_wr || lim_wr ||
                     reg_idx(awaddr_q) == `MAC_IDX_CONFIG) ? `MAC_RESP_OKAY : `MAC_RESP_SLVERR;
      end
      if (bvalid_q && S_AXI_BREADY_I) begin
        bvalid_q <= 1'b0;
        aw_rdy_q <= 1'b1;
        w_rdy_q  <= 1'b1;
      end
    end
  end

  // software registers; reserved config bits are kept as written
  always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      cfg_q  <= `MAC_RST_CONFIG;
      mask_q <= `MAC_RST_MASK;
      lim_q  <= `MAC_RST_LIMIT;
    end else begin
      if (cfg_wr) cfg_q <= cfg_new;
      if (mask_wr) mask_q <= ((mask_q & ~be16) | (wdata_q[15:0] & be16)) & `MAC_MSK_WMASK;
      if (lim_wr) lim_q <= (lim_q & ~be16) | (wdata_q[15:0] & be16);
    end
  end

  // read data mux; flags live outside mask_q
  always_comb begin
    rd_mux  = '0;
    rd_resp = `MAC_RESP_OKAY;
    case (reg_idx(S_AXI_ARADDR_I))
      `MAC_IDX_CONFIG: rd_mux[15:0] = cfg_q;
      `MAC_IDX_MASK: begin
        rd_mux[15:0]         = mask_q;
        rd_mux[`MAC_BIT_AFF]  = aff_q;
        rd_mux[`MAC_BIT_CONVERSION_READY_FLAG] = conversion_ready_flag_q;
      end
      `MAC_IDX_LIMIT:  rd_mux[15:0] = lim_q;
      `MAC_IDX_SHUNT:  rd_mux[15:0] = res_sh_q;
      `MAC_IDX_BUS:    rd_mux[15:0] = res_bus_q;
      `MAC_IDX_POWER:  rd_mux[15:0] = res_pw_q;
      `MAC_IDX_STATUS: begin
        rd_mux[`MAC_BIT_BUSY]  = state_q == mac_pkg::ST_SHUNT || state_q == mac_pkg::ST_BUS;
        rd_mux[`MAC_BIT_RECOV] = state_q == mac_pkg::ST_RECOVER;
      end
      default: rd_resp = `MAC_RESP_SLVERR;
    endcase
  end

  // read channel: one outstanding read, answer one cycle after address
  always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      ar_rdy_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q  <= '0;
      rresp_q  <= `MAC_RESP_OKAY;
    end else if (rd_go) begin
      ar_rdy_q <= 1'b0;
      rvalid_q <= 1'b1;
      rdata_q  <= rd_mux;
      rresp_q  <= rd_resp;
    end else if (rvalid_q && S_AXI_RREADY_I) begin
      rvalid_q <= 1'b0;
      ar_rdy_q <= 1'b1;
    end
  end

  // ---- conversion sequencing ----
  // a config write restarts the cycle, so it never collides with a completion
  assign cnt_zero  = cnt_q == '0;
  assign shf       = avg_shift(cfg.avg);
  assign n_last    = n_q == 11'((32'h1 << shf) - 1);
  assign shunt_end = state_q == mac_pkg::ST_SHUNT && cnt_zero && !cfg_wr;
  assign bus_end   = state_q == mac_pkg::ST_BUS && cnt_zero && !cfg_wr;
  assign cyc_done  = bus_end && n_last;

  always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      state_q <= mac_pkg::ST_RECOVER;
      cnt_q   <= CNT_W'(REC_CYC - 1);
      trig_q  <= 1'b0;
    end else if (cfg_wr) begin
      trig_q <= cfg_nw.mode == `MAC_MODE_SINGLE;
      if (!new_active) begin
        state_q <= mac_pkg::ST_DOWN;
      end else if (state_q == mac_pkg::ST_DOWN) begin
        state_q <= mac_pkg::ST_RECOVER;
        cnt_q   <= CNT_W'(REC_CYC - 1);
      end else if (state_q != mac_pkg::ST_RECOVER) begin
        state_q <= mac_pkg::ST_IDLE;
      end
    end else begin
      case (state_q)
        mac_pkg::ST_DOWN: state_q <= mac_pkg::ST_DOWN;
        mac_pkg::ST_RECOVER: begin
          if (cnt_zero) state_q <= mac_pkg::ST_IDLE;
          else cnt_q <= cnt_q - 1'b1;
        end
        mac_pkg::ST_IDLE: begin
          if (cfg.mode == `MAC_MODE_CONT || trig_q) begin
            state_q <= mac_pkg::ST_SHUNT;
            cnt_q   <= conv_cyc(cfg.shunt_ct);
            trig_q  <= 1'b0;
          end
        end
        mac_pkg::ST_SHUNT: begin
          if (cnt_zero) begin
            state_q <= mac_pkg::ST_BUS;
            cnt_q   <= conv_cyc(cfg.bus_ct);
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        mac_pkg::ST_BUS: begin
          if (!cnt_zero) begin
            cnt_q <= cnt_q - 1'b1;
          end else if (!n_last || cfg.mode == `MAC_MODE_CONT) begin
            state_q <= mac_pkg::ST_SHUNT;
            cnt_q   <= conv_cyc(cfg.shunt_ct);
          end else begin
            state_q <= mac_pkg::ST_IDLE;
          end
        end
        default: state_q <= mac_pkg::ST_IDLE;
      endcase
    end
  end

  // ---- accumulation and results ----
  assign shunt_mag = shunt_last_q[15] ? 16'(-shunt_last_q) : shunt_last_q;
  assign pwr_full  = shunt_mag * BUS_SAMPLE_I;
  assign pwr       = 16'(pwr_full >> `MAC_PWR_SHIFT);
  assign sum_sh    = acc_sh_q + 27'(SHUNT_SAMPLE_I);
  assign sum_bus   = acc_bus_q + 26'(BUS_SAMPLE_I);
  assign sum_pw    = acc_pw_q + 26'(pwr);

  always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      acc_sh_q     <= '0;
      acc_bus_q    <= '0;
      acc_pw_q     <= '0;
      n_q          <= '0;
      shunt_last_q <= '0;
      res_sh_q     <= '0;
      res_bus_q    <= '0;
      res_pw_q     <= '0;
    end else if (cfg_wr) begin
      acc_sh_q  <= '0;
      acc_bus_q <= '0;
      acc_pw_q  <= '0;
      n_q       <= '0;
    end else if (shunt_end) begin
      shunt_last_q <= SHUNT_SAMPLE_I;
      acc_sh_q     <= sum_sh;
    end else if (bus_end && !n_last) begin
      acc_bus_q <= sum_bus;
      acc_pw_q  <= sum_pw;
      n_q       <= n_q + 1'b1;
    end else if (cyc_done) begin
      res_sh_q  <= 16'(acc_sh_q >>> shf);
      res_bus_q <= 16'(sum_bus >> shf);
      res_pw_q  <= 16'(sum_pw >> shf);
      acc_sh_q  <= '0;
      acc_bus_q <= '0;
      acc_pw_q  <= '0;
      n_q       <= '0;
    end
  end

  // ---- limit comparison on each raw sample ----
  assign func     = sel_func(mask_q);
  assign sh_viol  = (func == mac_pkg::FN_SOL && SHUNT_SAMPLE_I > $signed(lim_q)) ||
                    (func == mac_pkg::FN_SUL && SHUNT_SAMPLE_I < $signed(lim_q));
  assign bus_viol = (func == mac_pkg::FN_BOL && BUS_SAMPLE_I > lim_q) ||
                    (func == mac_pkg::FN_BUL && BUS_SAMPLE_I < lim_q) ||
                    (func == mac_pkg::FN_POL && pwr > lim_q);
  assign cmp_evt  = (shunt_end && (func == mac_pkg::FN_SOL || func == mac_pkg::FN_SUL)) ||
                    (bus_end && (func == mac_pkg::FN_BOL || func == mac_pkg::FN_BUL ||
                                 func == mac_pkg::FN_POL));
  assign cmp_viol = shunt_end ? sh_viol : bus_viol;

  // flags: a setting event beats a clearing access in the same cycle
  always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      aff_q  <= 1'b0;
      conversion_ready_flag_q <= 1'b0;
    end else begin
      if (cmp_evt && cmp_viol) aff_q <= 1'b1;
      else if (cmp_evt && !mask_q[`MAC_BIT_LEN]) aff_q <= 1'b0;
      else if (mask_q[`MAC_BIT_LEN] && (cfg_wr || mask_rd)) aff_q <= 1'b0;
      if (cyc_done) conversion_ready_flag_q <= 1'b1;
      else if ((cfg_wr && !cfg_pd) || mask_rd) conversion_ready_flag_q <= 1'b0;
    end
  end

  // open drain: pull low when the logical level should read low
  assign alert_act = aff_q || (mask_q[`MAC_BIT_READY_SIGNAL_ENABLE] && conversion_ready_flag_q);
  always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      alert_oe_q <= 1'b0;
      ALERT_O    <= 1'b0;
    end else begin
      alert_oe_q <= alert_act ^ mask_q[`MAC_BIT_WARNING_POLARITY_SELECT];
      ALERT_O    <= 1'b0;
    end
  end

  assign ALERT_OE_O      = alert_oe_q;
  assign S_AXI_AWREADY_O = aw_rdy_q;
  assign S_AXI_WREADY_O  = w_rdy_q;
  assign S_AXI_BVALID_O  = bvalid_q;
  assign S_AXI_BRESP_O   = bresp_q;
  assign S_AXI_ARREADY_O = ar_rdy_q;
  assign S_AXI_RVALID_O  = rvalid_q;
  assign S_AXI_RDATA_O   = rdata_q;
  assign S_AXI_RRESP_O   = rresp_q;

  // ---- checks ----
  logic [CNT_W-1:0] rec_seen_q; // cycles spent in recovery
  always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
    if (!RST_B_I) rec_seen_q <= '0;
    else if (state_q == mac_pkg::ST_RECOVER) rec_seen_q <= rec_seen_q + 1'b1;
    else rec_seen_q <= '0;
  end

  a_recover_len: assert property (@(posedge CLK_SYS_I) disable iff (!RST_B_I)
    $fell(state_q == mac_pkg::ST_RECOVER) && !$past(cfg_wr) |-> $past(rec_seen_q) == CNT_W'(REC_CYC - 1))
    else $error("left recovery early");
  a_down_holds: assert property (@(posedge CLK_SYS_I) disable iff (!RST_B_I)
    state_q == mac_pkg::ST_DOWN && !cfg_wr |=> state_q == mac_pkg::ST_DOWN)
    else $error("left power-down without write");
  a_ready_set: assert property (@(posedge CLK_SYS_I) disable iff (!RST_B_I)
    cyc_done |=> conversion_ready_flag_q && $changed(res_bus_q) || conversion_ready_flag_q)
    else $error("ready flag not set");
  a_ready_clear: assert property (@(posedge CLK_SYS_I) disable iff (!RST_B_I)
    (mask_rd || (cfg_wr && !cfg_pd)) && !cyc_done |=> !conversion_ready_flag_q)
    else $error("ready flag not cleared");
  a_pd_keeps_ready: assert property (@(posedge CLK_SYS_I) disable iff (!RST_B_I)
    cfg_pd && conversion_ready_flag_q && !mask_rd |=> conversion_ready_flag_q)
    else $error("power-down write cleared ready");
  a_viol_sets_flag: assert property (@(posedge CLK_SYS_I) disable iff (!RST_B_I)
    cmp_evt && cmp_viol |=> aff_q ##1 (alert_oe_q == !mask_q[`MAC_BIT_WARNING_POLARITY_SELECT] || $changed(mask_q)))
    else $error("violation did not raise alert");
  a_latch_holds: assert property (@(posedge CLK_SYS_I) disable iff (!RST_B_I)
    aff_q && mask_q[`MAC_BIT_LEN] && !cfg_wr && !mask_rd && !mask_wr |=> aff_q)
    else $error("latched flag dropped");
  a_single_once: assert property (@(posedge CLK_SYS_I) disable iff (!RST_B_I)
    cyc_done && cfg.mode == `MAC_MODE_SINGLE |=> state_q == mac_pkg::ST_IDLE ##1
    (state_q == mac_pkg::ST_IDLE || $past(cfg_wr)))
    else $error("single shot repeated");
  a_cont_repeat: assert property (@(posedge CLK_SYS_I) disable iff (!RST_B_I)
    bus_end && cfg.mode == `MAC_MODE_CONT |=> state_q == mac_pkg::ST_SHUNT)
    else $error("continuous mode stopped");
  a_result_hold: assert property (@(posedge CLK_SYS_I) disable iff (!RST_B_I)
    !cyc_done |=> $stable(res_sh_q) && $stable(res_bus_q) && $stable(res_pw_q))
    else $error("result changed without completion");
  a_shunt_time: assert property (@(posedge CLK_SYS_I) disable iff (!RST_B_I)
    $rose(state_q == mac_pkg::ST_SHUNT) |-> cnt_q == conv_cyc(cfg.shunt_ct) || $past(cfg_wr))
    else $error("shunt time not loaded");
endmodule : mac_top
`default_nettype wire
